// ---- rtl/asc_amp_ctrl.sv ----
/*
 * Pin-level configuration of a two-channel switching amplifier: strap
 * capture at reset release, gain select, fault flags and bridge drive.
 * Assumes every control pin is asynchronous to sys_clk (20 MHz) and that
 * reset_n and mute_n are active-low pins from the host controller.
 */
// Overview of operation
// - External strap at reset release disables both stages
// - External mode leaves flags and dead-time meaningless
// - External mode outputs each channel bitstream on pin
// - Gain code maps to 0, 6, 12, 18 dB
// - Gain pins sampled continuously, applied on change
// - Diagonal bridge transistors switch together as pair
// - Eight dead-time settings from three select pins
// - Dead-time select captured at reset rising edge
// - Code 000 longest, 111 shortest dead time
// - Overcurrent latches mute; reset or mute pulse clears
`timescale 1ns/1ns
module asc_amp_ctrl
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // Host control pins
    input  wire logic                  reset_n,
    input  wire logic                  mute_n,
    input  wire logic                  external_modulator_strap,
    input  wire logic                  deadtime_sel_bit2,
    input  wire logic                  deadtime_sel_bit1,
    input  wire logic                  deadtime_sel_bit0,
    input  wire logic                  gain_sel_bit1,
    input  wire logic                  gain_sel_bit0,
    // Analog side
    input  wire logic                  left_mod_bit,
    input  wire logic                  right_mod_bit,
    input  asc_fault_s                 fault_in,
    // Outputs
    output logic [GAIN_SEL_W-1:0]      gain_code,
    output logic [4:0]                 gain_db,
    output asc_bridge_s                left_gates,
    output asc_bridge_s                right_gates,
    output logic                       left_bitstream_out,
    output logic                       right_bitstream_out,
    output logic                       thermal_shutdown_flag,
    output logic                       thermal_warning_flag,
    output logic                       overcurrent_flag,
    output logic [DT_SEL_W-1:0]        deadtime_sel,
    output logic                       ext_mode
);

    // One clock period in tenths of a ns, the unit of the dead-time table
    localparam int unsigned TENTHS_PER_NS = 10;
    localparam int unsigned CYCLE_TENTHS  = TENTHS_PER_NS * CLK_PERIOD_NS;
    localparam int unsigned MAX_DT_TENTHS = ((1 << DT_CNT_W) - 1) * CYCLE_TENTHS;

    // The counter must hold the longest gap in whole cycles
    if (DT_TENTH_NS[0] > MAX_DT_TENTHS) begin : g_bad_cnt_w
        $error("asc_amp_ctrl: DT_CNT_W too narrow for the longest dead time");
    end

    // Cycles of dead time, rounded up so the gap is never shorter
    function automatic logic [DT_CNT_W-1:0] dt_cycles(input logic [DT_SEL_W-1:0] code);
        int unsigned c;
        c = (DT_TENTH_NS[code] + CYCLE_TENTHS - 1) / CYCLE_TENTHS;
        if (c < 1) c = 1;
        return DT_CNT_W'(c);
    endfunction : dt_cycles

    function automatic logic [4:0] gain_lookup(input logic [GAIN_SEL_W-1:0] code);
        case (code)
            2'h0:    return GAIN_DB_0;
            2'h1:    return GAIN_DB_1;
            2'h2:    return GAIN_DB_2;
            default: return GAIN_DB_3;
        endcase
    endfunction : gain_lookup

    // Two-stage synchronisers; only stage two is read
    localparam int unsigned SYNC_W = 10;
    logic [SYNC_W-1:0] sync1_reg, sync2_reg;
    logic [SYNC_W-1:0] pin_bus;
    assign pin_bus = {reset_n, mute_n, external_modulator_strap, deadtime_sel_bit2,
                      deadtime_sel_bit1, deadtime_sel_bit0, gain_sel_bit1, gain_sel_bit0,
                      left_mod_bit, right_mod_bit};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_bus;
            sync2_reg <= sync1_reg;
        end
    end

    logic                  rst_n_s, mute_n_s, strap_s, lmod_s, rmod_s;
    logic [DT_SEL_W-1:0]   dt_s;
    logic [GAIN_SEL_W-1:0] gain_s;
    asc_fault_s            fault_s1_reg, fault_s2_reg;
    assign {rst_n_s, mute_n_s, strap_s, dt_s, gain_s, lmod_s, rmod_s} = sync2_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fault_s1_reg <= '0;
            fault_s2_reg <= '0;
        end else begin
            fault_s1_reg <= fault_in;
            fault_s2_reg <= fault_s1_reg;
        end
    end

    // Control state
    logic                  rst_n_d_reg, rst_n_d_next;
    logic                  mute_n_d_reg, mute_n_d_next;
    logic                  ext_reg, ext_next;
    logic [DT_SEL_W-1:0]   dt_reg, dt_next;
    logic [GAIN_SEL_W-1:0] gain_reg, gain_next;
    logic [4:0]            gain_db_reg, gain_db_next;
    logic                  oc_reg, oc_next;
    logic                  tw_reg, tw_next;
    logic                  ts_reg, ts_next;
    logic                  lbit_reg, lbit_next;
    logic                  rbit_reg, rbit_next;
    logic                  rise, mute_pulse_end;

    assign rise           = rst_n_s && !rst_n_d_reg;
    assign mute_pulse_end = mute_n_s && !mute_n_d_reg;

    always_comb begin
        rst_n_d_next  = rst_n_s;
        mute_n_d_next = mute_n_s;
        ext_next      = ext_reg;
        dt_next       = dt_reg;
        gain_next     = gain_s;
        gain_db_next  = gain_lookup(gain_s);
        oc_next       = oc_reg;
        tw_next       = 1'b0;
        ts_next       = 1'b0;
        lbit_next     = 1'b0;
        rbit_next     = 1'b0;
        if (rise) begin
            // Straps captured once and held until the next release
            ext_next = strap_s;
            dt_next  = dt_s;
        end
        if (!rst_n_s || mute_pulse_end) begin
            oc_next = 1'b0;
        end
        // Outputs follow the mode being captured, so none leaks in the capture cycle
        if (rst_n_s && !ext_next) begin
            // Latched flag; a new fault wins over a clear
            if (fault_s2_reg.overcurrent) oc_next = 1'b1;
            tw_next = fault_s2_reg.thermal_warning;
            ts_next = fault_s2_reg.thermal_shutdown;
        end
        if (rst_n_s && ext_next) begin
            // Flags stay low: they have no meaning here
            lbit_next = lmod_s;
            rbit_next = rmod_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rst_n_d_reg  <= 1'b0;
            mute_n_d_reg <= 1'b0;
            ext_reg      <= EXT_MOD_RESET;
            dt_reg       <= DT_SEL_RESET;
            gain_reg     <= '0;
            gain_db_reg  <= GAIN_DB_0;
            oc_reg       <= 1'b0;
            tw_reg       <= 1'b0;
            ts_reg       <= 1'b0;
            lbit_reg     <= 1'b0;
            rbit_reg     <= 1'b0;
        end else begin
            rst_n_d_reg  <= rst_n_d_next;
            mute_n_d_reg <= mute_n_d_next;
            ext_reg      <= ext_next;
            dt_reg       <= dt_next;
            gain_reg     <= gain_next;
            gain_db_reg  <= gain_db_next;
            oc_reg       <= oc_next;
            tw_reg       <= tw_next;
            ts_reg       <= ts_next;
            lbit_reg     <= lbit_next;
            rbit_reg     <= rbit_next;
        end
    end

    // Stage runs only out of reset, unmuted, free of overcurrent and thermal shutdown, and internal
    logic stage_en;
    // Held off in the capture cycle, where ext_reg still shows the old strap
    assign stage_en = rst_n_s && mute_n_s && !rise
                      && !ext_reg && !oc_reg && !ts_reg;

    // dt_reg changes only at reset release, so it is stable while running
    logic [DT_CNT_W-1:0] dead_cycles;
    assign dead_cycles = dt_cycles(dt_reg);

    asc_half_bridge #(.DEAD_W(DT_CNT_W)) u_left (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .enable      (stage_en),
        .mod_bit     (lmod_s),
        .dead_cycles (dead_cycles),
        .gates       (left_gates)
    );

    asc_half_bridge #(.DEAD_W(DT_CNT_W)) u_right (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .enable      (stage_en),
        .mod_bit     (rmod_s),
        .dead_cycles (dead_cycles),
        .gates       (right_gates)
    );

    assign gain_code             = gain_reg;
    assign gain_db               = gain_db_reg;
    assign left_bitstream_out    = lbit_reg;
    assign right_bitstream_out   = rbit_reg;
    assign thermal_shutdown_flag = ts_reg;
    assign thermal_warning_flag  = tw_reg;
    assign overcurrent_flag      = oc_reg;
    assign deadtime_sel          = dt_reg;
    assign ext_mode              = ext_reg;

endmodule : asc_amp_ctrl

// ---- rtl/asc_pkg.sv ----
/*
 * Shared constants and carrier types for the amplifier strap and power
 * stage control block. Assumes a single 20 MHz system clock.
 */
package asc_pkg;

    // Clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Select, gain and dead-time counter widths
    localparam int unsigned DT_SEL_W      = 3;
    localparam int unsigned GAIN_SEL_W    = 2;
    localparam int unsigned DT_CNT_W      = 4;

    // Dead time in tenths of a ns per code, longest first
    localparam int unsigned DT_TENTH_NS [8] = '{620, 490, 370, 240, 150, 135, 120, 90};

    // Reset values of captured straps
    localparam logic                EXT_MOD_RESET = 1'h0;
    localparam logic [DT_SEL_W-1:0] DT_SEL_RESET  = 3'h0;

    // Front-end gain in dB per code
    localparam logic [4:0] GAIN_DB_0 = 5'h00;
    localparam logic [4:0] GAIN_DB_1 = 5'h06;
    localparam logic [4:0] GAIN_DB_2 = 5'h0c;
    localparam logic [4:0] GAIN_DB_3 = 5'h12;

    // Four bridge gates of one channel
    typedef struct packed {
        logic high_a;
        logic low_a;
        logic high_b;
        logic low_b;
    } asc_bridge_s;

    // Fault inputs from the analog protection circuits
    typedef struct packed {
        logic overcurrent;
        logic thermal_warning;
        logic thermal_shutdown;
    } asc_fault_s;

endpackage : asc_pkg

// ---- rtl/asc_half_bridge.sv ----
/*
 * Non-overlap gate driver for one H-bridge channel. Assumes the modulator
 * bit and the enable come from logic on sys_clk.
 */
`timescale 1ns/1ns
module asc_half_bridge
    import asc_pkg::*;
#(
    parameter int unsigned DEAD_W = DT_CNT_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // Control
    input  wire logic              enable,
    input  wire logic              mod_bit,
    input  wire logic [DEAD_W-1:0] dead_cycles,
    // Gates
    output asc_bridge_s            gates
);

    if (DEAD_W < 1) begin : g_bad_dead_w
        $error("asc_half_bridge: DEAD_W must be at least 1");
    end

    logic              state_reg, state_next;
    logic [DEAD_W-1:0] cnt_reg,   cnt_next;
    asc_bridge_s       gates_reg, gates_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        gates_next = '0;
        if (!enable) begin
            cnt_next = dead_cycles;
        end else if (mod_bit != state_reg) begin
            // All gates off for the dead time before the new pair turns on
            state_next = mod_bit;
            cnt_next   = dead_cycles;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end else begin
            // Diagonal pairs switch together for differential drive
            gates_next.high_a = state_reg;
            gates_next.low_b  = state_reg;
            gates_next.high_b = !state_reg;
            gates_next.low_a  = !state_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= 1'b0;
            cnt_reg   <= '0;
            gates_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            gates_reg <= gates_next;
        end
    end

    assign gates = gates_reg;

endmodule : asc_half_bridge

// ---- tb/asc_amp_ctrl_chk.sv ----
/* Port assertions for asc_amp_ctrl.
   Assumes a bind onto the design and one clock domain. */
`timescale 1ns/1ns
module asc_amp_ctrl_chk
    import asc_pkg::*;
(
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset,
    // Pins
    input wire logic                  reset_n,
    input wire logic                  mute_n,
    input wire logic                  gain_sel_bit1,
    input wire logic                  gain_sel_bit0,
    input wire logic                  left_mod_bit,
    // Outputs
    input wire logic [GAIN_SEL_W-1:0] gain_code,
    input wire logic [4:0]            gain_db,
    input asc_bridge_s                left_gates,
    input asc_bridge_s                right_gates,
    input wire logic                  left_bitstream_out,
    input wire logic                  thermal_warning_flag,
    input wire logic                  overcurrent_flag,
    input wire logic [DT_SEL_W-1:0]   deadtime_sel,
    input wire logic                  ext_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    function automatic bit pair_ok(asc_bridge_s g);
        return g.high_a == g.low_b && g.high_b == g.low_a && !(g.high_a && g.high_b);
    endfunction : pair_ok
    property p_ext_gates; ext_mode |-> left_gates == 4'h0 && right_gates == 4'h0; endproperty
    a_ext_gates: assert property (p_ext_gates) else $error("gates on in external mode");
    property p_ext_flags; ext_mode |-> !thermal_warning_flag && !overcurrent_flag; endproperty
    a_ext_flags: assert property (p_ext_flags) else $error("flag in external mode");
    property p_bits; (ext_mode && reset_n && left_mod_bit)[*5] |-> left_bitstream_out; endproperty
    a_bits: assert property (p_bits) else $error("bitstream not shown");
    property p_gain_db; gain_db == 5'(gain_code) * 5'h06; endproperty
    a_gain_db: assert property (p_gain_db) else $error("gain dB mismatch");
    property p_gain;
        $stable({gain_sel_bit1, gain_sel_bit0})[*5] |-> gain_code == {gain_sel_bit1, gain_sel_bit0};
    endproperty
    a_gain: assert property (p_gain) else $error("gain pins not followed");
    property p_pair; pair_ok(left_gates) && pair_ok(right_gates); endproperty
    a_pair: assert property (p_pair) else $error("bridge pair broken");
    property p_dead; $fell(left_gates.high_a) |-> (left_gates == 4'h0)[*2]; endproperty
    a_dead: assert property (p_dead) else $error("no dead time");
    property p_held; reset_n[*5] |-> $stable(deadtime_sel) && $stable(ext_mode); endproperty
    a_held: assert property (p_held) else $error("strap moved");
    property p_oc; (reset_n && mute_n)[*6] ##0 overcurrent_flag |=> overcurrent_flag; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent flag dropped");
    c_ext: cover property (ext_mode && left_bitstream_out);
    c_oc: cover property ($fell(overcurrent_flag));
    c_dead: cover property ($fell(left_gates.high_a));
endmodule : asc_amp_ctrl_chk
bind asc_amp_ctrl asc_amp_ctrl_chk u_chk (.*);

// ---- tb/asc_host.sv ----
/* Host controller model driving the reset, mute and strap pins.
   Assumes commands from the bench; pins move on the falling edge. */
`timescale 1ns/1ns
module asc_host (
    // Clock
    input wire logic       sys_clk,
    // Commands
    input wire logic       cmd_rn,
    input wire logic       cmd_mn,
    input wire logic       cmd_strap,
    input wire logic [2:0] cmd_dt,
    input wire logic [1:0] cmd_gain,
    // Pins
    output logic           rn,
    output logic           mn,
    output logic           strap,
    output logic [2:0]     dt,
    output logic [1:0]     gain
);
    initial begin
        {rn, mn, strap, dt, gain} = 8'h00;
    end
    always @(negedge sys_clk) begin
        rn <= cmd_rn;
        mn <= cmd_mn;
        gain <= cmd_gain;
        // A real host may not move straps out of reset, so commands then wait
        if (!rn) begin
            strap <= cmd_strap;
            dt <= cmd_dt;
        end
    end
endmodule : asc_host

// ---- tb/tb_asc_amp_ctrl.sv ----
/* Self-checking bench for asc_amp_ctrl with a host model.
   Assumes a 20 MHz clock and bench drive on the falling edge. */
`timescale 1ns/1ns
module tb_asc_amp_ctrl;
    import asc_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, cmd_rn = 1'b0, cmd_mn = 1'b0, cmd_strap = 1'b0;
    logic [2:0] cmd_dt = 3'h0;
    logic [1:0] cmd_gain = 2'h0;
    logic rn, mn, strap, lm = 1'b0, rm = 1'b0, lb, rb, ts, tw, oc, ext;
    logic [2:0] dt, dsel;
    logic [1:0] gain, gcode;
    logic [4:0] gdb;
    logic [31:0] r;
    asc_fault_s fault = '0;
    asc_bridge_s lg, rg;
    int error_cnt = 0, cmp_count = 0, m_ext, m_dt, n0, n7;
    initial forever #25 sys_clk = ~sys_clk;
    asc_host host (.sys_clk(sys_clk), .cmd_rn(cmd_rn), .cmd_mn(cmd_mn), .cmd_strap(cmd_strap),
        .cmd_dt(cmd_dt), .cmd_gain(cmd_gain), .rn(rn), .mn(mn), .strap(strap), .dt(dt),
        .gain(gain));
    asc_amp_ctrl dut (.sys_clk(sys_clk), .reset(reset), .reset_n(rn), .mute_n(mn),
        .external_modulator_strap(strap), .deadtime_sel_bit2(dt[2]), .deadtime_sel_bit1(dt[1]),
        .deadtime_sel_bit0(dt[0]), .gain_sel_bit1(gain[1]), .gain_sel_bit0(gain[0]),
        .left_mod_bit(lm), .right_mod_bit(rm), .fault_in(fault), .gain_code(gcode),
        .gain_db(gdb), .left_gates(lg), .right_gates(rg), .left_bitstream_out(lb),
        .right_bitstream_out(rb), .thermal_shutdown_flag(ts), .thermal_warning_flag(tw),
        .overcurrent_flag(oc), .deadtime_sel(dsel), .ext_mode(ext));
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic end_sim;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Reset cycle with new straps, then a refused strap change out of reset
    task automatic start(input int s, input int d);
        cmd_rn <= 1'b0;
        cmd_strap <= 1'(s);
        cmd_dt <= 3'(d);
        cyc(5);
        cmd_rn <= 1'b1;
        cyc(8);
        m_ext = s;
        m_dt = d;
        chk("ext_mode", 5'(m_ext), 5'(ext));
        chk("deadtime_sel", 5'(m_dt), 5'(dsel));
        cmd_dt <= ~3'(d);
        cmd_strap <= ~1'(s);
        cyc(6);
        chk("held", 5'(m_dt * 2 + m_ext), {1'b0, dsel, ext});
    endtask : start
    // Length of the idle gap after a modulator edge
    task automatic dead(output int n);
        n = 0;
        lm <= ~lm;
        for (int i = 0; i < 10 && lg !== 4'h0; i++) cyc(1);
        for (int i = 0; i < 20 && lg === 4'h0; i++) begin
            n++;
            cyc(1);
        end
    endtask : dead
    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        void'($urandom(3270));
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) reset <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            start(i % 2, i / 2);
            for (int k = 0; k < 4; k++) begin
                r = $urandom;
                {rm, lm, cmd_gain} <= r[3:0];
                fault.thermal_warning <= r[4];
                fault.thermal_shutdown <= r[5];
                cyc(6);
                chk("gain_db", 5'(r[1:0]) * 5'h06, gdb);
                chk("gain_code", 5'(r[1:0]), 5'(gcode));
                chk("thermal_shutdown_flag", 5'(!m_ext && r[5]), 5'(ts));
                chk("right_gates", 5'h00, 5'(rg));
                chk("bitstreams", 5'(m_ext ? r[3:2] : 0), {3'h0, rb, lb});
                chk("thermal_warning_flag", 5'(!m_ext && r[4]), 5'(tw));
                chk("left_gates", 5'h00, 5'(lg));
            end
        end
        fault <= '0;
        {lm, rm} <= 2'h3;
        cmd_mn <= 1'b1;
        start(0, 0);
        chk("left_gates", 5'h09, 5'(lg));
        chk("right_gates", 5'h09, 5'(rg));
        dead(n0);
        start(0, 7);
        dead(n7);
        chk("dead gap", 5'h01, 5'(n0 - n7));
        fault.overcurrent <= 1'b1;
        cyc(6);
        fault.overcurrent <= 1'b0;
        cyc(6);
        chk("overcurrent_flag", 5'h01, 5'(oc));
        chk("left_gates", 5'h00, 5'(lg));
        cmd_mn <= 1'b0;
        cyc(6);
        cmd_mn <= 1'b1;
        cyc(6);
        chk("overcurrent_flag", 5'h00, 5'(oc));
        fault.thermal_shutdown <= 1'b1;
        cyc(6);
        chk("thermal_shutdown_flag", 5'h01, 5'(ts));
        chk("left_gates", 5'h00, 5'(lg));
        fault.thermal_shutdown <= 1'b0;
        cyc(6);
        chk("thermal_shutdown_flag", 5'h00, 5'(ts));
        chk("left_gates", 5'h09, 5'(lg));
        fault.overcurrent <= 1'b1;
        cyc(6);
        fault.overcurrent <= 1'b0;
        start(0, 7);
        chk("overcurrent_flag", 5'h00, 5'(oc));
        end_sim();
    end
endmodule : tb_asc_amp_ctrl
